// ---- rtl/scr_filler_none.sv ----
// no logic here; the block is the top module and its byte-lane storage

// ---- rtl/scr_mem.sv ----
// two byte-wide storage arrays with registered read data
`timescale 1ns/1ps
module scr_mem
   import scr_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // access port
   scr_mem_if.mem    mp
);

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
   } scr_mem_st_t;

   // storage has no reset; contents unknown until written
   logic [BYTE_W-1:0] lane_mem [NUM_BYTES][DEPTH];
   scr_mem_st_t       st_q;
   scr_mem_st_t       st_d;

   always_comb begin
      st_d = st_q;
      if (mp.en && !mp.we) begin
         for (int b = 0; b < NUM_BYTES; b++) begin
            st_d.rdata[b*BYTE_W +: BYTE_W] = lane_mem[b][mp.addr];
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int b = 0; b < NUM_BYTES; b++) begin
         if (mp.en && mp.we && mp.be[b]) begin
            lane_mem[b][mp.addr] <= mp.wdata[b*BYTE_W +: BYTE_W];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '{rdata: DATA_RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign mp.rdata = st_q.rdata;

endmodule : scr_mem

// ---- rtl/scr_mem_if.sv ----
// port between the cache ram control and its byte-lane storage
`timescale 1ns/1ps
interface scr_mem_if;
   import scr_pkg::*;

   logic                        en;
   logic                        we;
   logic [NUM_BYTES-1:0]        be;
   logic [ADDR_W-1:0]           addr;
   logic [DATA_W-1:0]           wdata;
   logic [DATA_W-1:0]           rdata;

   modport ctrl (output en, output we, output be, output addr,
                 output wdata, input rdata);
   modport mem  (input en, input we, input be, input addr,
                 input wdata, output rdata);

endinterface : scr_mem_if

// ---- rtl/scr_pkg.sv ----
// constants and pin bundle for the synchronous cache ram
package scr_pkg;

   localparam int ADDR_W    = 14;
   localparam int DATA_W    = 16;
   localparam int BYTE_W    = 8;
   localparam int NUM_BYTES = 2;
   localparam int DEPTH     = 16384;

   // self-timed write pulse, least time
   localparam int CLK_PERIOD_NS = 4;
   localparam int WR_TIME_NS    = 8;
   localparam int WR_CYC_RAW    =
      (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_CYCLES     = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
   localparam int WCNT_W        = 4;
   localparam logic [WCNT_W-1:0] WR_LOAD = WCNT_W'(WR_CYCLES - 1);
   localparam logic [WCNT_W-1:0] WCNT_ZERO = '0;

   localparam logic [ADDR_W-1:0]    ADDR_RST = 14'h0000;
   localparam logic [DATA_W-1:0]    DATA_RST = 16'h0000;
   localparam logic [NUM_BYTES-1:0] BE_NONE  = 2'h0;
   localparam logic [NUM_BYTES-1:0] WE_IDLE  = 2'h3;

   // pin inputs travel together through the synchroniser
   typedef struct packed {
      logic                 sys_clk;
      logic                 oe_n;
      logic [NUM_BYTES-1:0] we_n;
      logic [ADDR_W-1:0]    addr;
      logic [DATA_W-1:0]    dq;
   } scr_pins_t;

   localparam int PIN_W = $bits(scr_pins_t);
   localparam scr_pins_t PINS_RST = '{
      sys_clk: 1'b0,
      oe_n:    1'b1,
      we_n:    WE_IDLE,
      addr:    ADDR_RST,
      dq:      DATA_RST
   };

endpackage : scr_pkg

// ---- rtl/scr_top.sv ----
// synchronous byte-write cache ram behind its pins
`timescale 1ns/1ps
module scr_top
   import scr_pkg::*;
(
   // core clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // shared system clock pin
   input  wire logic                 sys_clk,
   // control pins
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [NUM_BYTES-1:0] we_n,
   input  wire logic                 oe_n,
   // data pins
   input  wire logic [DATA_W-1:0]    dq_i,
   output      logic [DATA_W-1:0]    dq_o,
   output      logic                 dq_oe_n
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_READ
   } scr_state_t;

   typedef struct packed {
      scr_pins_t            s1;
      scr_pins_t            s2;
      scr_pins_t            s3;
      scr_pins_t            flt;
      scr_state_t           state;
      logic [ADDR_W-1:0]    addr_reg;
      logic [ADDR_W-1:0]    waddr;
      logic [DATA_W-1:0]    din;
      logic [NUM_BYTES-1:0] wbe;
      logic [WCNT_W-1:0]    wcnt;
      logic                 rd_pend;
      logic [DATA_W-1:0]    dout;
      logic                 oe_n;
   } scr_top_st_t;

   scr_top_st_t st_q;
   scr_top_st_t st_d;
   scr_pins_t   pin_w;

   scr_mem_if   mif ();

   // a bit only moves once the second and third stages agree
   function automatic scr_pins_t settle(input scr_pins_t a,
                                        input scr_pins_t b,
                                        input scr_pins_t hold);
      logic [PIN_W-1:0] agree;
      agree = ~(a ^ b);
      return (agree & b) | (~agree & hold);
   endfunction : settle

   assign pin_w.sys_clk = sys_clk;
   assign pin_w.oe_n    = oe_n;
   assign pin_w.we_n    = we_n;
   assign pin_w.addr    = addr;
   assign pin_w.dq      = dq_i;

   always_comb begin
      scr_pins_t nxt;
      logic      rise;
      logic      fall;
      logic      wr_go;
      nxt   = settle(st_q.s2, st_q.s3, st_q.flt);
      rise  = nxt.sys_clk && !st_q.flt.sys_clk;
      fall  = !nxt.sys_clk && st_q.flt.sys_clk;
      wr_go = 1'b0;

      st_d     = st_q;
      st_d.s1  = pin_w;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      st_d.flt = nxt;

      mif.en    = 1'b0;
      mif.we    = 1'b0;
      mif.be    = BE_NONE;
      mif.addr  = st_q.addr_reg;
      mif.wdata = st_q.din;

      // drivers follow the enable alone; strobes never release them
      st_d.oe_n = nxt.oe_n;

      // all pins share one delay, so the edge sees aligned inputs
      if (rise) begin
         st_d.addr_reg = nxt.addr;
         st_d.rd_pend  = 1'b1;
      end

      case (st_q.state)
         ST_IDLE: begin
            if (st_q.rd_pend) begin
               mif.en       = 1'b1;
               mif.we       = 1'b0;
               mif.addr     = st_q.addr_reg;
               st_d.rd_pend = rise;
               st_d.state   = ST_READ;
            end
         end
         ST_WRITE: begin
            if (st_q.wcnt == WCNT_ZERO) begin
               // write lands before any queued read is served
               mif.en       = 1'b1;
               mif.we       = 1'b1;
               mif.be       = st_q.wbe;
               mif.addr     = st_q.waddr;
               mif.wdata    = st_q.din;
               st_d.rd_pend = 1'b1;
               st_d.state   = ST_IDLE;
            end else begin
               st_d.wcnt = st_q.wcnt - 1'b1;
            end
         end
         ST_READ: begin
            st_d.dout  = mif.rdata;
            st_d.state = ST_IDLE;
         end
         default: begin
            st_d.state = ST_IDLE;
         end
      endcase

      // a fall during a pending write is ignored; the bus clock is slow
      if (fall && st_q.state != ST_WRITE) begin
         if (nxt.we_n != WE_IDLE) begin
            wr_go = 1'b1;
         end
      end

      if (wr_go) begin
         st_d.din   = nxt.dq;
         st_d.wbe   = ~nxt.we_n;
         st_d.waddr = rise ? nxt.addr : st_d.addr_reg;
         st_d.wcnt  = WR_LOAD;
         st_d.state = ST_WRITE;
         // a read in flight still finishes into the output latch
         if (st_q.state == ST_READ) begin
            st_d.dout = mif.rdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '{
            s1:       PINS_RST,
            s2:       PINS_RST,
            s3:       PINS_RST,
            flt:      PINS_RST,
            state:    ST_IDLE,
            addr_reg: ADDR_RST,
            waddr:    ADDR_RST,
            din:      DATA_RST,
            wbe:      BE_NONE,
            wcnt:     WCNT_ZERO,
            rd_pend:  1'b0,
            dout:     DATA_RST,
            oe_n:     1'b1
         };
      end else begin
         st_q <= st_d;
      end
   end

   scr_mem u_mem (
      .clk   (clk),
      .rst_n (rst_n),
      .mp    (mif.mem)
   );

   assign dq_o    = st_q.dout;
   assign dq_oe_n = st_q.oe_n;

endmodule : scr_top

// ---- test/scr_host_model.sv ----
// controller model driving the shared system clock and pins
`timescale 1ns/1ps
module scr_host_model
   import scr_pkg::*;
(
   // core clock
   input  wire logic                 clk,
   // shared system clock and control pins
   output      logic                 sys_clk,
   output      logic [ADDR_W-1:0]    addr,
   output      logic [NUM_BYTES-1:0] we_n,
   output      logic                 oe_n,
   // data the controller puts on the bus
   output      logic [DATA_W-1:0]    host_dq
);
   initial begin
      sys_clk = 1'b0;
      addr    = 14'h0000;
      we_n    = WE_IDLE;
      oe_n    = 1'b1;
      host_dq = 16'h0000;
   end
   // one system clock period, 25 core cycles, ends just before next rise
   task automatic cyc(input logic [ADDR_W-1:0] a,
      input logic [NUM_BYTES-1:0] w, input logic oe_hi,
      input logic [DATA_W-1:0] d);
      @(posedge clk) #1;
      sys_clk = 1'b1;
      addr    = a;
      we_n    = w;
      oe_n    = oe_hi;
      // released bus shows the inverse, never a stale value
      host_dq = oe_hi ? d : ~host_dq;
      repeat (12) @(posedge clk);
      #1 sys_clk = 1'b0;
      repeat (12) @(posedge clk);
      // callers sample outputs off the edge that could launch them
      #1;
   endtask : cyc
endmodule : scr_host_model

// ---- test/scr_top_properties.sv ----
// pin-level properties of the cache ram top
`timescale 1ns/1ps
module scr_checker
   import scr_pkg::*;
(
   // clock and reset
   input wire logic                 clk,
   input wire logic                 rst_n,
   // pins
   input wire logic                 sys_clk,
   input wire logic [ADDR_W-1:0]    addr,
   input wire logic [NUM_BYTES-1:0] we_n,
   input wire logic                 oe_n,
   input wire logic [DATA_W-1:0]    dq_i,
   input wire logic [DATA_W-1:0]    dq_o,
   input wire logic                 dq_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // data held stable until the write lands
   sequence s_dq_held;
      ##1 $stable(dq_i)[*8];
   endsequence
   sequence s_fall(logic [NUM_BYTES-1:0] w);
      $fell(sys_clk) && we_n == w;
   endsequence
   property p_wr_full;
      s_fall(2'h0) ##0 s_dq_held |-> ##4 dq_o == dq_i;
   endproperty
   property p_wr_lo;
      s_fall(2'h2) ##0 s_dq_held |-> ##4 dq_o[7:0] == dq_i[7:0];
   endproperty
   property p_wr_hi;
      s_fall(2'h1) ##0 s_dq_held |-> ##4 dq_o[15:8] == dq_i[15:8];
   endproperty
   property p_no_wr;
      s_fall(2'h3) |-> $stable(dq_o)[*8];
   endproperty
   property p_rise_hold;
      $rose(sys_clk) |-> $stable(dq_o)[*5];
   endproperty
   property p_oe_drive;
      $fell(oe_n) |-> ##[1:6] !dq_oe_n;
   endproperty
   property p_oe_release;
      $rose(oe_n) |-> ##[1:6] dq_oe_n;
   endproperty
   property p_oe_level;
      $stable(oe_n)[*8] |-> dq_oe_n == oe_n;
   endproperty
   a_wr_full: assert property (p_wr_full)
      else $error("full word write not seen");
   a_wr_lo: assert property (p_wr_lo)
      else $error("low lane write not seen");
   a_wr_hi: assert property (p_wr_hi)
      else $error("high lane write not seen");
   a_no_wr: assert property (p_no_wr)
      else $error("output moved without write");
   a_rise_hold: assert property (p_rise_hold)
      else $error("read data not held past rise");
   a_oe_drive: assert property (p_oe_drive)
      else $error("pins not driven");
   a_oe_release: assert property (p_oe_release)
      else $error("pins not released");
   a_oe_level: assert property (p_oe_level)
      else $error("direction differs from enable");
endmodule : scr_checker
bind scr_top scr_checker u_chk (.clk(clk), .rst_n(rst_n), .sys_clk(sys_clk),
   .addr(addr), .we_n(we_n), .oe_n(oe_n), .dq_i(dq_i), .dq_o(dq_o),
   .dq_oe_n(dq_oe_n));

// ---- test/tb.sv ----
// self-checking bench for the cache ram top
`timescale 1ns/1ps
module tb;
   import scr_pkg::*;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 sys_clk, oe_n, dq_oe_n;
   logic [ADDR_W-1:0]    addr;
   logic [NUM_BYTES-1:0] we_n;
   logic [DATA_W-1:0]    host_dq, dq_i, dq_o;
   int                   mismatches = 0, samples_checked = 0, cycles = 0;
   always #2 clk = ~clk;
   assign dq_i = dq_oe_n ? host_dq : dq_o;
   scr_host_model u_host (.clk(clk), .sys_clk(sys_clk), .addr(addr),
      .we_n(we_n), .oe_n(oe_n), .host_dq(host_dq));
   scr_top u_dut (.clk(clk), .rst_n(rst_n), .sys_clk(sys_clk), .addr(addr),
      .we_n(we_n), .oe_n(oe_n), .dq_i(dq_i), .dq_o(dq_o),
      .dq_oe_n(dq_oe_n));
   task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task t_word;
      u_host.cyc(14'h0001, 2'h0, 1'b1, 16'hA5C3);
      chk({15'h0000, dq_oe_n}, 16'h0001);
      u_host.cyc(14'h0001, WE_IDLE, 1'b0, 16'h0000);
      chk(dq_o, 16'hA5C3);
      chk({15'h0000, dq_oe_n}, 16'h0000);
      $display("word test done");
   endtask : t_word
   task t_lanes;
      u_host.cyc(14'h0001, 2'h2, 1'b1, 16'h1177);
      u_host.cyc(14'h0001, 2'h1, 1'b1, 16'h9900);
      u_host.cyc(14'h0001, WE_IDLE, 1'b0, 16'h0000);
      chk(dq_o, 16'h9977);
      $display("lane test done");
   endtask : t_lanes
   task t_idle;
      u_host.cyc(14'h0001, WE_IDLE, 1'b1, 16'h0000);
      u_host.cyc(14'h0001, WE_IDLE, 1'b0, 16'h0000);
      chk(dq_o, 16'h9977);
      $display("idle test done");
   endtask : t_idle
   task t_bounds;
      u_host.cyc(14'h3FFF, 2'h0, 1'b1, 16'h1234);
      u_host.cyc(14'h0000, 2'h0, 1'b1, 16'h5678);
      u_host.cyc(14'h3FFF, WE_IDLE, 1'b0, 16'h0000);
      chk(dq_o, 16'h1234);
      u_host.cyc(14'h0000, WE_IDLE, 1'b0, 16'h0000);
      chk(dq_o, 16'h5678);
      $display("bounds test done");
   endtask : t_bounds
   // run takes about 290 core cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1500) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clk);
      t_word();
      t_lanes();
      t_idle();
      t_bounds();
      stop_test();
   end
endmodule : tb
